// *** rtoa_axis.sv ***
// rotary table output axis: gear scaling, clutch gating, checks and APB registers
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
module rtoa_axis (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // drive module and servo feedback
   input wire logic drive_valid,
   input wire logic signed [31:0] drive_speed,
   input wire logic signed [31:0] drive_travel,
   input wire logic signed [31:0] aux_travel,
   input wire logic signed [31:0] deviation_count,
   // servo amplifier command
   output rtoa_pkg::rtoa_cmd_s servo_cmd,
   output logic cmd_valid,
   output logic [15:0] torque_limit,
   // status and positions
   output logic axis_error_flag,
   output rtoa_pkg::rtoa_pos_s main_rev_pos,
   output rtoa_pkg::rtoa_pos_s aux_rev_pos
);
   typedef enum logic [1:0] {DV_IDLE = 2'b00, DV_TPR = 2'b01, DV_DPP = 2'b11} rtoa_div_e;

   logic [rtoa_pkg::CTRL_W-1:0] ctrl_reg;
   logic [31:0] gear_reg, ppr_reg, trv_reg, backlash_reg, droop_reg;
   logic [31:0] up_reg, lo_reg, ceil_reg, tpr_reg, main_reg, aux_reg, angle_reg;
   logic signed [31:0] feed_reg;
   logic [15:0] torque_reg;
   logic [41:0] dpp_reg;
   logic [rtoa_pkg::ST_W-1:0] status_reg, err_set;
   logic [15:0] frac_main_reg, frac_aux_reg;
   logic dir_neg_reg, moved_reg, virt_d_reg, recalc_reg;
   rtoa_div_e div_state_reg;
   logic div_start, div_busy, div_done;
   logic [63:0] div_num, div_den, div_q;
   logic wr_en, setup, mapped;
   logic signed [63:0] acc_main, acc_aux, spd_scaled;
   logic signed [31:0] trv_main, trv_aux, trv_gated, bl_add;
   logic clutch_open, reverse, ref_zero, stroke_on, in_range;
   logic [31:0] spd_abs, dev_abs;
   logic [79:0] spd_lhs, spd_rhs;

   // gear product plus carried fraction, unsigned 16.16 ratio
   function automatic logic signed [63:0] gear_scale(input logic signed [31:0] x, input logic [31:0] g,
                                                      input logic [15:0] f);
      gear_scale = x * $signed({32'h0000_0000, g}) + $signed({48'h0000_0000_0000, f});
   endfunction

   // step a within-revolution position and wrap into 0 .. tpr-1
   function automatic logic [31:0] rev_step(input logic [31:0] p, input logic signed [31:0] d,
                                           input logic [31:0] tpr);
      logic signed [33:0] s;
      s = $signed({2'b00, p}) + 34'(d);
      if (s < 0)
         s = s + $signed({2'b00, tpr});
      else if (s >= $signed({2'b00, tpr}))
         s = s - $signed({2'b00, tpr});
      rev_step = s[31:0];
   endfunction

   // magnitude of a signed word
   function automatic logic [31:0] mag(input logic signed [31:0] v);
      mag = (v < 0) ? 32'(-v) : 32'(v);
   endfunction

   // register address decode
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a[1:0] == 2'b00) && (a <= rtoa_pkg::OFS_FEED_POS);
   endfunction

   // bus phases: no wait states, write lands on the access edge
   assign setup = psel && !penable;
   assign mapped = is_mapped(paddr);
   assign wr_en = psel && penable && pready && pwrite && mapped;

   // gear scaling of both inputs and of speed
   assign acc_main = gear_scale(drive_travel, gear_reg, frac_main_reg);
   assign acc_aux = gear_scale(aux_travel, gear_reg, frac_aux_reg);
   assign spd_scaled = gear_scale(drive_speed, gear_reg, 16'h0000);
   assign trv_main = acc_main[rtoa_pkg::GEAR_FRAC +: 32];
   assign trv_aux = acc_aux[rtoa_pkg::GEAR_FRAC +: 32];

   // clutch gate and backlash on direction reversal
   assign clutch_open = ctrl_reg[rtoa_pkg::CTRL_CL_PRES] && !ctrl_reg[rtoa_pkg::CTRL_CL_ENG];
   assign trv_gated = (clutch_open || !ctrl_reg[rtoa_pkg::CTRL_VIRT]) ? 32'sd0 : trv_main;
   assign reverse = moved_reg && (trv_gated != 0) && ((trv_gated < 0) != dir_neg_reg);
   assign bl_add = !reverse ? 32'sd0 : (trv_gated < 0) ? -$signed(backlash_reg) : $signed(backlash_reg);
   assign ref_zero = ctrl_reg[rtoa_pkg::CTRL_VIRT] && !virt_d_reg && ctrl_reg[rtoa_pkg::CTRL_CL_REF];

   // checks: droop, stroke window (may wrap through zero), speed ceiling
   assign dev_abs = mag(deviation_count);
   assign spd_abs = mag(spd_scaled[rtoa_pkg::GEAR_FRAC +: 32]);
   assign stroke_on = (up_reg != lo_reg);
   assign in_range = (lo_reg < up_reg) ? (angle_reg >= lo_reg && angle_reg <= up_reg)
                                       : (angle_reg >= lo_reg || angle_reg <= up_reg);
   assign spd_lhs = 80'(spd_abs) * 80'(dpp_reg) * 80'(rtoa_pkg::SPD_LHS_K);
   assign spd_rhs = (80'(ceil_reg) * 80'(ctrl_reg[rtoa_pkg::CTRL_SPD_X10] ? rtoa_pkg::SPD_RHS_K10
                                         : rtoa_pkg::SPD_RHS_K)) << rtoa_pkg::GEAR_FRAC;
   always_comb
   begin
      err_set = '0;
      err_set[rtoa_pkg::ST_DROOP] = dev_abs > droop_reg;
      err_set[rtoa_pkg::ST_STROKE] = ctrl_reg[rtoa_pkg::CTRL_VIRT] && stroke_on && !in_range;
      err_set[rtoa_pkg::ST_SPEED] = spd_lhs > spd_rhs;
   end

   // settings written by software; out-of-range values are refused
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= '0;
         gear_reg <= rtoa_pkg::GEAR_DEF;
         ppr_reg <= rtoa_pkg::FIX_PPR_DEF;
         trv_reg <= rtoa_pkg::FIX_TRAVEL_DEF;
         backlash_reg <= '0;
         droop_reg <= rtoa_pkg::DROOP_DEF;
         up_reg <= '0;
         lo_reg <= '0;
         ceil_reg <= rtoa_pkg::SPEED_CEIL_MAX;
         torque_reg <= rtoa_pkg::TORQUE_DEF;
      end
      else if (wr_en)
      begin
         unique case (paddr)
            rtoa_pkg::OFS_CTRL: ctrl_reg <= pwdata[rtoa_pkg::CTRL_W-1:0];
            rtoa_pkg::OFS_GEAR: gear_reg <= pwdata;
            rtoa_pkg::OFS_FIX_PPR: ppr_reg <= pwdata;
            rtoa_pkg::OFS_FIX_TRAVEL: if (pwdata != 0) trv_reg <= pwdata;
            rtoa_pkg::OFS_BACKLASH: backlash_reg <= pwdata;
            rtoa_pkg::OFS_DROOP: if (pwdata != 0 && pwdata <= rtoa_pkg::DROOP_MAX) droop_reg <= pwdata;
            rtoa_pkg::OFS_STROKE_UP: if (pwdata <= rtoa_pkg::STROKE_MAX) up_reg <= pwdata;
            rtoa_pkg::OFS_STROKE_LO: if (pwdata <= rtoa_pkg::STROKE_MAX) lo_reg <= pwdata;
            rtoa_pkg::OFS_SPEED_CEIL: if (pwdata != 0 && pwdata <= rtoa_pkg::SPEED_CEIL_MAX) ceil_reg <= pwdata;
            rtoa_pkg::OFS_TORQUE: torque_reg <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // sticky error flags; a new event wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         status_reg <= '0;
      else if (wr_en && paddr == rtoa_pkg::OFS_STATUS)
         status_reg <= (status_reg & ~pwdata[rtoa_pkg::ST_W-1:0]) | err_set;
      else
         status_reg <= status_reg | err_set;
   end

   // error only flags; nothing here feeds back into the command path
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         axis_error_flag <= 1'b0;
      else
         axis_error_flag <= |(status_reg | err_set);
   end

   // derived fixed quantities, recomputed after reset and after any fixed write
   assign div_start = (div_state_reg != DV_IDLE) && !div_busy && !div_done;
   assign div_num = (div_state_reg == DV_TPR) ? 64'(ppr_reg) * 64'(rtoa_pkg::DEG_FULL)
                                               : {16'h0000, rtoa_pkg::DEG_FULL, 16'h0000};
   assign div_den = (div_state_reg == DV_TPR) ? 64'(trv_reg) : 64'(tpr_reg);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_state_reg <= DV_TPR;
         recalc_reg <= 1'b0;
         tpr_reg <= '0;
         dpp_reg <= '0;
      end
      else
      begin
         if (wr_en && (paddr == rtoa_pkg::OFS_FIX_PPR || paddr == rtoa_pkg::OFS_FIX_TRAVEL))
            recalc_reg <= 1'b1;
         unique case (div_state_reg)
            DV_IDLE:
               if (recalc_reg)
               begin
                  div_state_reg <= DV_TPR;
                  recalc_reg <= 1'b0;
               end
            DV_TPR:
               if (div_done)
               begin
                  tpr_reg <= (div_q[31:0] == 0) ? 32'h0000_0001 : div_q[31:0];
                  div_state_reg <= DV_DPP;
               end
            DV_DPP:
               if (div_done)
               begin
                  dpp_reg <= div_q[41:0];
                  div_state_reg <= DV_IDLE;
               end
            default: div_state_reg <= DV_IDLE;
         endcase
      end
   end

   rtoa_divider #(.W(rtoa_pkg::DIV_W)) u_div (
      .pclk(pclk),
      .presetn(presetn),
      .start(div_start),
      .dividend(div_num),
      .divisor(div_den),
      .busy(div_busy),
      .done(div_done),
      .quotient(div_q)
   );

   // command path: gated, backlash added, registered toward the amplifier
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         servo_cmd <= '0;
         cmd_valid <= 1'b0;
         frac_main_reg <= '0;
         frac_aux_reg <= '0;
         dir_neg_reg <= 1'b0;
         moved_reg <= 1'b0;
      end
      else
      begin
         cmd_valid <= drive_valid && ctrl_reg[rtoa_pkg::CTRL_VIRT];
         if (drive_valid)
         begin
            frac_main_reg <= acc_main[rtoa_pkg::GEAR_FRAC-1:0];
            frac_aux_reg <= acc_aux[rtoa_pkg::GEAR_FRAC-1:0];
            servo_cmd.travel <= trv_gated + bl_add;
            servo_cmd.speed <= (trv_gated == 0 && clutch_open) ? 32'sd0
                                                               : spd_scaled[rtoa_pkg::GEAR_FRAC +: 32];
            if (trv_gated != 0)
            begin
               dir_neg_reg <= trv_gated < 0;   // kept through mode switches
               moved_reg <= 1'b1;
            end
         end
      end
   end

   // feed position only accumulates; never cleared by a mode change
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         feed_reg <= '0;
      else if (drive_valid)
         feed_reg <= feed_reg + trv_gated;
   end

   // within-revolution positions, both updated regardless of clutch
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         main_reg <= '0;
         aux_reg <= '0;
         virt_d_reg <= 1'b0;
         angle_reg <= '0;
      end
      else
      begin
         virt_d_reg <= ctrl_reg[rtoa_pkg::CTRL_VIRT];
         angle_reg <= 32'((64'(main_reg) * 64'(dpp_reg)) >> rtoa_pkg::GEAR_FRAC);
         if (ref_zero)
         begin
            main_reg <= '0;
            aux_reg <= '0;
         end
         else if (drive_valid && ctrl_reg[rtoa_pkg::CTRL_VIRT])
         begin
            main_reg <= rev_step(main_reg, trv_main, tpr_reg);
            aux_reg <= rev_step(aux_reg, trv_aux, tpr_reg);
         end
      end
   end

   // two-word stores and torque limit, always valid in virtual mode
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         main_rev_pos <= '0;
         aux_rev_pos <= '0;
         torque_limit <= rtoa_pkg::TORQUE_DEF;
      end
      else
      begin
         main_rev_pos <= main_reg;
         aux_rev_pos <= aux_reg;
         torque_limit <= ctrl_reg[rtoa_pkg::CTRL_TRQ_SRC] ? torque_reg : rtoa_pkg::TORQUE_DEF;
      end
   end

   // read data captured in the setup cycle, answered in the access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= setup;
         pslverr <= setup && !mapped;
         if (setup && !pwrite)
         begin
            unique case (paddr)
               rtoa_pkg::OFS_CTRL: prdata <= 32'(ctrl_reg);
               rtoa_pkg::OFS_GEAR: prdata <= gear_reg;
               rtoa_pkg::OFS_FIX_PPR: prdata <= ppr_reg;
               rtoa_pkg::OFS_FIX_TRAVEL: prdata <= trv_reg;
               rtoa_pkg::OFS_BACKLASH: prdata <= backlash_reg;
               rtoa_pkg::OFS_DROOP: prdata <= droop_reg;
               rtoa_pkg::OFS_STROKE_UP: prdata <= up_reg;
               rtoa_pkg::OFS_STROKE_LO: prdata <= lo_reg;
               rtoa_pkg::OFS_SPEED_CEIL: prdata <= ceil_reg;
               rtoa_pkg::OFS_TORQUE: prdata <= 32'(torque_reg);
               rtoa_pkg::OFS_STATUS: prdata <= 32'(status_reg);
               rtoa_pkg::OFS_TPR: prdata <= tpr_reg;
               rtoa_pkg::OFS_DEG_PP: prdata <= dpp_reg[31:0];
               rtoa_pkg::OFS_MAIN_POS: prdata <= main_reg;
               rtoa_pkg::OFS_AUX_POS: prdata <= aux_reg;
               rtoa_pkg::OFS_FEED_POS: prdata <= feed_reg;
               default: prdata <= '0;
            endcase
         end
      end
   end
endmodule

// *** rtoa_pkg.sv ***
// package: register map, field layout, defaults and carriers of the rotary table output axis
package rtoa_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_GEAR = 8'h04;
   localparam logic [7:0] OFS_FIX_PPR = 8'h08;
   localparam logic [7:0] OFS_FIX_TRAVEL = 8'h0c;
   localparam logic [7:0] OFS_BACKLASH = 8'h10;
   localparam logic [7:0] OFS_DROOP = 8'h14;
   localparam logic [7:0] OFS_STROKE_UP = 8'h18;
   localparam logic [7:0] OFS_STROKE_LO = 8'h1c;
   localparam logic [7:0] OFS_SPEED_CEIL = 8'h20;
   localparam logic [7:0] OFS_TORQUE = 8'h24;
   localparam logic [7:0] OFS_STATUS = 8'h28;
   localparam logic [7:0] OFS_TPR = 8'h2c;
   localparam logic [7:0] OFS_DEG_PP = 8'h30;
   localparam logic [7:0] OFS_MAIN_POS = 8'h34;
   localparam logic [7:0] OFS_AUX_POS = 8'h38;
   localparam logic [7:0] OFS_FEED_POS = 8'h3c;
   // control bit positions
   localparam int CTRL_VIRT = 0;
   localparam int CTRL_CL_PRES = 1;
   localparam int CTRL_CL_ENG = 2;
   localparam int CTRL_CL_REF = 3;
   localparam int CTRL_SPD_X10 = 4;
   localparam int CTRL_TRQ_SRC = 5;
   localparam int CTRL_W = 6;
   // status bit positions, write one to clear
   localparam int ST_DROOP = 0;
   localparam int ST_STROKE = 1;
   localparam int ST_SPEED = 2;
   localparam int ST_W = 3;
   // reset values and legal ranges
   localparam logic [31:0] GEAR_DEF = 32'h0001_0000;      // unsigned 16.16, ratio one
   localparam int GEAR_FRAC = 16;
   localparam logic [31:0] FIX_PPR_DEF = 32'h0000_4e20;
   localparam logic [31:0] FIX_TRAVEL_DEF = 32'h0225_5100;  // 360 degrees in 0.00001 units
   localparam logic [31:0] DEG_FULL = 32'h0225_5100;        // 360 degrees in 0.00001 units
   localparam logic [31:0] DROOP_DEF = 32'h0063_ff9c;       // 6553500
   localparam logic [31:0] DROOP_MAX = 32'h4000_0000;       // 1073741824
   localparam logic [31:0] STROKE_MAX = 32'h0225_50ff;      // 359.99999 degrees
   localparam logic [31:0] SPEED_CEIL_MAX = 32'h7fff_ffff;  // 2147483.647 or 21474836.47 deg/min
   localparam logic [15:0] TORQUE_DEF = 16'h012c;           // 300 percent
   // degree/min in 0.001 or 0.01 units against pulses/s times 0.00001 degree: x5/3 or x50/3
   localparam logic [7:0] SPD_LHS_K = 8'h03;
   localparam logic [7:0] SPD_RHS_K = 8'h05;
   localparam logic [7:0] SPD_RHS_K10 = 8'h32;
   localparam int DIV_W = 64;
   // one command to the servo amplifier
   typedef struct packed {
      logic signed [31:0] speed;
      logic signed [31:0] travel;
   } rtoa_cmd_s;
   // two-word within-revolution position
   typedef struct packed {
      logic [15:0] hi;
      logic [15:0] lo;
   } rtoa_pos_s;
endpackage

// *** rtoa_divider.sv ***
// sequential restoring divider used for the fixed-parameter derived quantities
`timescale 1ns/1ps
module rtoa_divider #(
   parameter int W = 64
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // request
   input wire logic start,
   input wire logic [W-1:0] dividend,
   input wire logic [W-1:0] divisor,
   // answer
   output logic busy,
   output logic done,
   output logic [W-1:0] quotient
);
   logic [W-1:0] rem_reg;
   logic [W-1:0] num_reg;
   logic [W-1:0] den_reg;
   logic [$clog2(W+1)-1:0] cnt_reg;
   logic [W:0] trial;

   // shift one dividend bit into the partial remainder
   assign trial = {rem_reg, num_reg[W-1]} - {1'b0, den_reg};

   // one quotient bit per cycle, W cycles per division
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rem_reg <= '0;
         num_reg <= '0;
         den_reg <= '0;
         cnt_reg <= '0;
         busy <= 1'b0;
         done <= 1'b0;
         quotient <= '0;
      end
      else
      begin
         done <= 1'b0;
         if (start && !busy)
         begin
            rem_reg <= '0;
            num_reg <= dividend;
            den_reg <= divisor;
            cnt_reg <= ($clog2(W+1))'(W);
            busy <= 1'b1;
         end
         else if (busy)
         begin
            if (!trial[W])
               rem_reg <= trial[W-1:0];
            else
               rem_reg <= {rem_reg[W-2:0], num_reg[W-1]};
            num_reg <= {num_reg[W-2:0], ~trial[W]};
            cnt_reg <= cnt_reg - 1'b1;
            if (cnt_reg == 1)
            begin
               busy <= 1'b0;
               done <= 1'b1;
               quotient <= {num_reg[W-2:0], ~trial[W]};
            end
         end
      end
   end
endmodule

// *** rtoa_checker.sv ***
// checker: port-level properties of the rotary table output axis
`timescale 1ns/1ps
module rtoa_checker (
   // clock, reset and apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // drive, feedback and outputs
   input wire logic drive_valid,
   input wire logic signed [31:0] deviation_count,
   input wire rtoa_pkg::rtoa_cmd_s servo_cmd,
   input wire logic cmd_valid,
   input wire logic [15:0] torque_limit,
   input wire logic axis_error_flag
);
   logic [31:0] droop_reg;
   // completed writes by target
   wire wr_done = psel && penable && pwrite && pready;
   wire ctrl_w = wr_done && paddr == rtoa_pkg::OFS_CTRL;
   wire trq_w = ctrl_w || (wr_done && paddr == rtoa_pkg::OFS_TORQUE);
   wire clr_w = wr_done && paddr == rtoa_pkg::OFS_STATUS;
   // shadow droop limit; out-of-range writes dropped as the block does
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         droop_reg <= rtoa_pkg::DROOP_DEF;
      else if (wr_done && paddr == rtoa_pkg::OFS_DROOP && pwdata != 32'h0 && pwdata <= rtoa_pkg::DROOP_MAX)
         droop_reg <= pwdata;
   end
   // one domain only
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_pready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready is not a one-cycle answer to setup");
   a_slverr_unmapped: assert property (psel && !penable && (paddr > 8'h3c || paddr[1:0] != 2'h0) |=> pslverr)
      else $error("unmapped access not refused");
   a_cmd_cause: assert property (cmd_valid |-> $past(drive_valid))
      else $error("command without a drive sample");
   a_cmd_stands: assert property (!$past(drive_valid) |-> $stable(servo_cmd))
      else $error("command changed without a drive sample");
   a_droop_flag: assert property (deviation_count > $signed({1'b0, droop_reg}) |-> ##[1:3] axis_error_flag)
      else $error("droop overrun not flagged");
   a_keeps_moving: assert property (cmd_valid && drive_valid && !ctrl_w && !$past(ctrl_w) |=> cmd_valid)
      else $error("axis stopped without a mode change");
   a_flag_sticky: assert property (axis_error_flag && !clr_w && !$past(clr_w) && !$past(clr_w, 2)
      |=> axis_error_flag)
      else $error("error flag dropped without a clear");
   a_torque_hold: assert property (!$past(trq_w) && !$past(trq_w, 2) |-> $stable(torque_limit))
      else $error("torque limit moved without a setting change");
endmodule

// *** rtoa_servo_model.sv ***
// servo amplifier stand-in: integrates commanded travel, reports following error
`timescale 1ns/1ps
module rtoa_servo_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // command from the axis, and a bench stall that stops the motor following
   input wire rtoa_pkg::rtoa_cmd_s servo_cmd,
   input wire logic cmd_valid,
   input wire logic stall,
   // feedback
   output logic signed [31:0] deviation_count
);
   logic signed [31:0] cmd_pos_reg;
   logic signed [31:0] act_pos_reg;
   // motor lags one cycle when free, so small droop shows even in good runs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmd_pos_reg <= 32'h0;
         act_pos_reg <= 32'h0;
      end
      else
      begin
         if (cmd_valid)
            cmd_pos_reg <= cmd_pos_reg + servo_cmd.travel;
         if (!stall)
            act_pos_reg <= cmd_pos_reg;
      end
   end
   assign deviation_count = cmd_pos_reg - act_pos_reg;
endmodule

// *** testbench.sv ***
// self-checking bench of the rotary table output axis over apb
`timescale 1ns/1ps
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, drive_valid, stall, cv, err;
   logic cmd_valid, axis_error_flag;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic signed [31:0] drive_speed, drive_travel, aux_travel, deviation_count;
   logic [15:0] torque_limit;
   rtoa_pkg::rtoa_cmd_s servo_cmd;
   rtoa_pkg::rtoa_pos_s main_rev_pos, aux_rev_pos;
   int fail_count, checked;
   logic [7:0] ofs [5] = '{rtoa_pkg::OFS_GEAR, rtoa_pkg::OFS_DROOP, rtoa_pkg::OFS_STROKE_UP,
      rtoa_pkg::OFS_STROKE_LO, rtoa_pkg::OFS_SPEED_CEIL};
   logic [31:0] dfl [5] = '{rtoa_pkg::GEAR_DEF, rtoa_pkg::DROOP_DEF, 32'h0, 32'h0, rtoa_pkg::SPEED_CEIL_MAX};
   rtoa_axis u_rtoa_axis (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .drive_valid, .drive_speed, .drive_travel, .aux_travel, .deviation_count, .servo_cmd,
      .cmd_valid, .torque_limit, .axis_error_flag, .main_rev_pos, .aux_rev_pos);
   rtoa_servo_model u_rtoa_servo_model (.pclk, .presetn, .servo_cmd, .cmd_valid, .stall, .deviation_count);
   // 200 mhz clock
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one transfer, then an idle cycle so psel is never driven twice per step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, rd, e);
   endtask
   // drive samples for n cycles; cmd_valid caught in its last cycle
   task automatic drv(input logic [31:0] spd, input logic [31:0] trv, input int n);
      drive_speed <= spd;
      drive_travel <= trv;
      aux_travel <= $signed(trv) / 2;
      drive_valid <= 1'b1;
      repeat (n) @(posedge pclk);
      drive_valid <= 1'b0;
      @(posedge pclk);
      cv = cmd_valid;
      repeat (3) @(posedge pclk);
   endtask
   task automatic fchk(input logic e, input string nm);
      repeat (3) @(posedge pclk);
      chk(nm, {31'h0, axis_error_flag}, {31'h0, e});
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // hang guard at 10000 cycles, far beyond the few hundred cycles the tests need
   initial
   begin
      #50000;
      fail_count++;
      results();
   end
   // test sequence
   initial
   begin
      {psel, penable, pwrite, drive_valid, stall, presetn} = 6'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      {drive_speed, drive_travel, aux_travel} = 96'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (ofs[i])
         rchk(ofs[i], dfl[i], "reset value");
      chk("torque", {16'h0, torque_limit}, 32'h12c);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
      repeat (200) @(posedge pclk);
      rchk(rtoa_pkg::OFS_TPR, 32'h4e20, "table pulses");
      rchk(rtoa_pkg::OFS_DEG_PP, 32'h0708_0000, "degrees per pulse");
      apb(1'b1, rtoa_pkg::OFS_FIX_TRAVEL, 32'h0112_a880);
      repeat (200) @(posedge pclk);
      rchk(rtoa_pkg::OFS_TPR, 32'h9c40, "table pulses");
      rchk(rtoa_pkg::OFS_DEG_PP, 32'h0384_0000, "degrees per pulse");
      $display("test derived counts done");
      // gear 1.5, then clutch fitted open and closed
      apb(1'b1, rtoa_pkg::OFS_GEAR, 32'h0001_8000);
      apb(1'b1, rtoa_pkg::OFS_CTRL, 32'h1);
      drv(32'h3e8, 32'ha, 1);
      chk("cmd valid", {31'h0, cv}, 32'h1);
      chk("cmd speed", servo_cmd.speed, 32'h5dc);
      chk("cmd travel", servo_cmd.travel, 32'hf);
      apb(1'b1, rtoa_pkg::OFS_CTRL, 32'h3);
      drv(32'h3e8, 32'ha, 1);
      chk("open clutch", servo_cmd.travel, 32'h0);
      apb(1'b1, rtoa_pkg::OFS_CTRL, 32'h7);
      drv(32'h3e8, 32'ha, 1);
      chk("closed clutch", servo_cmd.travel, 32'hf);
      // reference zero on entry, then wrap past one revolution
      apb(1'b1, rtoa_pkg::OFS_CTRL, 32'h0);
      apb(1'b1, rtoa_pkg::OFS_CTRL, 32'h9);
      repeat (3) @(posedge pclk);
      chk("main zeroed", main_rev_pos, 32'h0);
      chk("aux zeroed", aux_rev_pos, 32'h0);
      drv(32'h0, 32'h4e20, 1);
      drv(32'h0, 32'h4e20, 1);
      chk("main position", main_rev_pos, 32'h4e20);
      chk("aux position", aux_rev_pos, 32'h7530);
      rchk(rtoa_pkg::OFS_FEED_POS, 32'hea7e, "feed position");
      // first reversal adds the backlash in the new direction
      apb(1'b1, rtoa_pkg::OFS_BACKLASH, 32'h5);
      drv(32'h0, 32'hffff_fff6, 1);
      chk("backlash", servo_cmd.travel, 32'hffff_ffec);
      apb(1'b1, rtoa_pkg::OFS_TORQUE, 32'h1f4);
      apb(1'b1, rtoa_pkg::OFS_CTRL, 32'h21);
      repeat (2) @(posedge pclk);
      chk("torque", {16'h0, torque_limit}, 32'h1f4);
      $display("test motion done");
      // droop overrun with a stalled motor
      apb(1'b1, rtoa_pkg::OFS_DROOP, 32'h64);
      apb(1'b1, rtoa_pkg::OFS_DROOP, 32'h0);
      rchk(rtoa_pkg::OFS_DROOP, 32'h64, "droop");
      apb(1'b1, rtoa_pkg::OFS_STATUS, 32'h7);
      stall <= 1'b1;
      drv(32'h3e8, 32'h64, 2);
      fchk(1'b1, "droop flag");
      chk("moving", {31'h0, cv}, 32'h1);
      stall <= 1'b0;
      fchk(1'b1, "sticky flag");
      apb(1'b1, rtoa_pkg::OFS_STATUS, 32'h7);
      drv(32'h3e8, 32'h0, 1);
      fchk(1'b0, "stroke off");
      apb(1'b1, rtoa_pkg::OFS_STROKE_LO, 32'hc350);
      apb(1'b1, rtoa_pkg::OFS_STROKE_UP, 32'h0001_86a0);
      drv(32'h3e8, 32'h0, 1);
      fchk(1'b1, "stroke flag");
      chk("moving", {31'h0, cv}, 32'h1);
      $display("test checks done");
      // same raw ceiling: 200 degree/min flags, 2000 in ten-times units does not
      apb(1'b1, rtoa_pkg::OFS_STROKE_UP, 32'hc350);
      apb(1'b1, rtoa_pkg::OFS_SPEED_CEIL, 32'h0);
      rchk(rtoa_pkg::OFS_SPEED_CEIL, rtoa_pkg::SPEED_CEIL_MAX, "ceiling");
      for (int k = 0; k < 2; k++)
      begin
         apb(1'b1, rtoa_pkg::OFS_CTRL, k == 0 ? 32'h1 : 32'h11);
         apb(1'b1, rtoa_pkg::OFS_SPEED_CEIL, 32'h0003_0d40);
         apb(1'b1, rtoa_pkg::OFS_STATUS, 32'h7);
         drv(32'h3e8, 32'h0, 1);
         fchk(k == 0, "speed flag");
         chk("unclamped", servo_cmd.speed, 32'h5dc);
      end
      chk("torque", {16'h0, torque_limit}, 32'h12c);
      $display("test speed done");
      results();
   end
endmodule
bind rtoa_axis rtoa_checker u_rtoa_checker (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .pslverr, .drive_valid, .deviation_count, .servo_cmd, .cmd_valid, .torque_limit, .axis_error_flag);
